/* File: design/gpio_port_pkg.sv */
// Package for the general purpose port block: register addresses,
// reset values and port widths.
// Assumes a byte-wide special function register access port.
package gpio_port_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned PIN_COUNT = 17;
  localparam int unsigned P2_PIN = 16;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT0_LATCH = 8'h80;
  localparam logic [7:0] ADDR_PORT1_LATCH = 8'h90;
  localparam logic [7:0] ADDR_PORT2_LATCH = 8'hA0;
  localparam logic [7:0] ADDR_PORT0_OUTPUT_MODE = 8'hA4;
  localparam logic [7:0] ADDR_PORT1_OUTPUT_MODE = 8'hA5;
  localparam logic [7:0] ADDR_PORT2_OUTPUT_MODE = 8'hA6;
  localparam logic [7:0] ADDR_PORT0_CROSSBAR_SKIP = 8'hD4;
  localparam logic [7:0] ADDR_PORT1_CROSSBAR_SKIP = 8'hD5;
  localparam logic [7:0] ADDR_PORT0_INPUT_MODE = 8'hF1;
  localparam logic [7:0] ADDR_PORT1_INPUT_MODE = 8'hF2;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LATCH = 8'hFF;
  localparam logic RST_PORT2_LATCH = 1'h1;
  localparam logic [7:0] RST_OUTPUT_MODE = 8'h00;
  localparam logic RST_PORT2_OUTPUT_MODE = 1'h0;
  localparam logic [7:0] RST_CROSSBAR_SKIP = 8'h00;
  localparam logic [6:0] RST_PORT1_SKIP = 7'h00;
  localparam logic [7:0] RST_INPUT_MODE = 8'hFF;
  localparam logic [16:0] RST_PIN_OUT = 17'h00000;
  localparam logic [7:0] RST_RDATA = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned PORT1_SKIP_MSB = 6;
endpackage : gpio_port_pkg

/* File: design/general_purpose_port_io.sv */
// General purpose port logic for seventeen pins on three ports:
// output latches, input and output mode, crossbar skip, pin drive.
// Assumes the core presents byte and bit accesses on one SFR port,
// flags read-modify-write reads, and a crossbar outside supplies
// peripheral ownership, peripheral data and two-wire bus pin marks.
`timescale 1ns/1ps
module general_purpose_port_io (
  input wire logic core_clk_i,
  input wire logic reset_i,
  // SFR access port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_bit_wr_i,
  input wire logic [2:0] sfr_bit_idx_i,
  input wire logic sfr_bit_wdata_i,
  input wire logic sfr_rd_i,
  input wire logic sfr_rmw_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_rbit_o,
  // Crossbar side
  input wire logic crossbar_global_enable_i,
  input wire logic weak_pullup_disable_i,
  input wire logic [16:0] xbar_claim_i,
  input wire logic [16:0] xbar_data_i,
  input wire logic [16:0] two_wire_pin_i,
  output logic [14:0] crossbar_skip_o,
  output logic [16:0] pin_digital_o,
  // Pins
  input wire logic [16:0] pin_i,
  output logic [16:0] pin_o,
  output logic [16:0] pin_oe_o,
  output logic [16:0] pin_pullup_o
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] port0_latch_ff; // Port 0 output latch
  logic [7:0] port1_latch_ff; // Port 1 output latch
  logic port2_latch_ff; // Port 2 single latch bit
  logic [7:0] port0_input_mode_ff; // 1 digital, 0 analog
  logic [7:0] port1_input_mode_ff; // 1 digital, 0 analog
  logic [7:0] port0_output_mode_ff; // 1 push-pull, 0 open-drain
  logic [7:0] port1_output_mode_ff; // 1 push-pull, 0 open-drain
  logic port2_output_mode_ff; // Port 2 pin 0 mode
  logic [7:0] port0_crossbar_skip_ff; // Skip marks, port 0
  logic [6:0] port1_crossbar_skip_ff; // Skip marks, port 1 (bit 7 absent)
  logic [7:0] rdata_ff; // Registered read data
  logic rbit_ff; // Registered bit test result
  logic [16:0] pin_out_ff; // Registered pin drive level
  logic [16:0] pin_oe_ff; // Registered pin enable
  logic [16:0] pin_pullup_ff; // Registered pullup enable

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  logic [16:0] pin_meta_ff; // First stage, read only by second
  logic [16:0] pin_sync_ff; // Second stage, safe to use

  // Pins are asynchronous to the core clock
  // The synchroniser has no reset on purpose: a reset would only
  // hide the pin level for two more cycles and cost reset fan-out.
  // Software reading a port right after reset may see stale bits
  // for two edges; the register read path adds one more edge.
  // Only the second stage feeds the read path, so a metastable
  // first stage never reaches the read multiplexer.
  always_ff @(posedge core_clk_i) begin
    pin_meta_ff <= pin_i;
    pin_sync_ff <= pin_meta_ff;
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire sel_p0 = (sfr_addr_i == gpio_port_pkg::ADDR_PORT0_LATCH);
  wire sel_p1 = (sfr_addr_i == gpio_port_pkg::ADDR_PORT1_LATCH);
  wire sel_p2 = (sfr_addr_i == gpio_port_pkg::ADDR_PORT2_LATCH);
  wire sel_p0_mdout = (sfr_addr_i == gpio_port_pkg::ADDR_PORT0_OUTPUT_MODE);
  wire sel_p1_mdout = (sfr_addr_i == gpio_port_pkg::ADDR_PORT1_OUTPUT_MODE);
  wire sel_p2_mdout = (sfr_addr_i == gpio_port_pkg::ADDR_PORT2_OUTPUT_MODE);
  wire sel_p0_skip = (sfr_addr_i == gpio_port_pkg::ADDR_PORT0_CROSSBAR_SKIP);
  wire sel_p1_skip = (sfr_addr_i == gpio_port_pkg::ADDR_PORT1_CROSSBAR_SKIP);
  wire sel_p0_mdin = (sfr_addr_i == gpio_port_pkg::ADDR_PORT0_INPUT_MODE);
  wire sel_p1_mdin = (sfr_addr_i == gpio_port_pkg::ADDR_PORT1_INPUT_MODE);

  // Every select compares the full byte address, so no alias of a
  // register appears elsewhere in the special function space.
  // Writes to addresses that match none of these are dropped and
  // reads of them return zero, so the block can share the space
  // with other function registers without a separate enable.
  //
  // Single-bit write mask; only the latches are bit addressable
  wire [7:0] bit_mask = 8'h01 << sfr_bit_idx_i;
  wire [7:0] bit_fill = {8{sfr_bit_wdata_i}};

  // ----------------------------------------------------------------
  // Latch next values
  // ----------------------------------------------------------------
  logic [7:0] nxt_port0_latch; // Next port 0 latch
  logic [7:0] nxt_port1_latch; // Next port 1 latch
  logic nxt_port2_latch; // Next port 2 latch

  // Byte write replaces, bit write merges into the latch
  // A byte write wins over a bit write in the same cycle; the core
  // never issues both, so the order only keeps the logic defined.
  // Port 2 has a single latch bit: a bit write with any index other
  // than zero addresses an absent bit and leaves the latch alone.
  always_comb begin
    nxt_port0_latch = port0_latch_ff;
    nxt_port1_latch = port1_latch_ff;
    nxt_port2_latch = port2_latch_ff;
    if (sfr_wr_i && sel_p0) begin
      nxt_port0_latch = sfr_wdata_i;
    end else if (sfr_bit_wr_i && sel_p0) begin
      nxt_port0_latch = (port0_latch_ff & ~bit_mask) | (bit_fill & bit_mask);
    end
    if (sfr_wr_i && sel_p1) begin
      nxt_port1_latch = sfr_wdata_i;
    end else if (sfr_bit_wr_i && sel_p1) begin
      nxt_port1_latch = (port1_latch_ff & ~bit_mask) | (bit_fill & bit_mask);
    end
    if (sfr_wr_i && sel_p2) begin
      nxt_port2_latch = sfr_wdata_i[0];
    end else if (sfr_bit_wr_i && sel_p2 && (sfr_bit_idx_i == 3'h0)) begin
      nxt_port2_latch = sfr_bit_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // latch holds value
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      port0_latch_ff <= gpio_port_pkg::RST_LATCH;
      port1_latch_ff <= gpio_port_pkg::RST_LATCH;
      port2_latch_ff <= gpio_port_pkg::RST_PORT2_LATCH;
    end else begin
      port0_latch_ff <= nxt_port0_latch;
      port1_latch_ff <= nxt_port1_latch;
      port2_latch_ff <= nxt_port2_latch;
    end
  end

  // Mode and skip registers take byte writes only
  // Absent bits are never stored, so they cannot come back on a
  // read; this keeps the read multiplexer free of extra masking.
  // Skip marks are only stored here; the crossbar decoder outside
  // acts on them when it hands pins to peripherals.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      port0_input_mode_ff <= gpio_port_pkg::RST_INPUT_MODE;
      port1_input_mode_ff <= gpio_port_pkg::RST_INPUT_MODE;
      port0_output_mode_ff <= gpio_port_pkg::RST_OUTPUT_MODE;
      port1_output_mode_ff <= gpio_port_pkg::RST_OUTPUT_MODE;
      port2_output_mode_ff <= gpio_port_pkg::RST_PORT2_OUTPUT_MODE;
      port0_crossbar_skip_ff <= gpio_port_pkg::RST_CROSSBAR_SKIP;
      port1_crossbar_skip_ff <= gpio_port_pkg::RST_PORT1_SKIP;
    end else if (sfr_wr_i) begin
      if (sel_p0_mdin) begin
        port0_input_mode_ff <= sfr_wdata_i;
      end
      if (sel_p1_mdin) begin
        port1_input_mode_ff <= sfr_wdata_i;
      end
      if (sel_p0_mdout) begin
        port0_output_mode_ff <= sfr_wdata_i;
      end
      if (sel_p1_mdout) begin
        port1_output_mode_ff <= sfr_wdata_i;
      end
      if (sel_p2_mdout) begin
        port2_output_mode_ff <= sfr_wdata_i[0];
      end
      if (sel_p0_skip) begin
        port0_crossbar_skip_ff <= sfr_wdata_i;
      end
      if (sel_p1_skip) begin
        port1_crossbar_skip_ff <= sfr_wdata_i[gpio_port_pkg::PORT1_SKIP_MSB:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-pin configuration vectors
  // ----------------------------------------------------------------
  // Port 2 pin has no input-mode bit, so it is always digital
  wire [16:0] digital = {1'b1, port1_input_mode_ff, port0_input_mode_ff};
  wire [16:0] push_pull = {port2_output_mode_ff, port1_output_mode_ff,
                           port0_output_mode_ff};
  wire [16:0] latch_all = {port2_latch_ff, port1_latch_ff, port0_latch_ff};

  assign crossbar_skip_o = {port1_crossbar_skip_ff, port0_crossbar_skip_ff};
  assign pin_digital_o = digital;

  // ----------------------------------------------------------------
  // Pin drive logic
  // ----------------------------------------------------------------
  logic [16:0] nxt_pin_out; // Drive level per pin
  logic [16:0] nxt_pin_oe; // Driver enable per pin
  logic [16:0] nxt_pin_pullup; // Weak pullup per pin

  // Per pin: pick the drive level, then decide whether the driver is
  // on. Open-drain pins only ever drive low; a high level is left to
  // the weak pullup or to the outside circuitry. Analog pins and a
  // disabled crossbar turn the driver off completely, whatever the
  // latch or the peripheral asks for.
  // Limitation: a claimed pin follows the output mode bit like any
  // other pin, so software must still set push-pull where needed.
  genvar g;
  generate
    for (g = 0; g < gpio_port_pkg::PIN_COUNT; g = g + 1) begin : g_pin
      wire level = xbar_claim_i[g] ? xbar_data_i[g] : latch_all[g];
      // mode only on digital, non-bus pins
      wire pp = push_pull[g] & digital[g] & ~two_wire_pin_i[g];
      // drive low on 0; high only in push-pull
      wire drive = crossbar_global_enable_i & digital[g] & (pp | ~level);
      assign nxt_pin_out[g] = level & pp;
      // no driver when disabled or analog
      assign nxt_pin_oe[g] = drive;
      // open-drain pullup, off while driving low
      assign nxt_pin_pullup[g] = ~weak_pullup_disable_i & digital[g] & ~pp
                                 & ~drive;
    end
  endgenerate

  // Registered so pins change cleanly once per clock
  // Trade-off: one cycle of latency from a register write to the
  // pin, bought for glitch-free enables when several mode bits
  // change together. Reset leaves every driver and pullup off.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pin_out_ff <= gpio_port_pkg::RST_PIN_OUT;
      pin_oe_ff <= gpio_port_pkg::RST_PIN_OUT;
      pin_pullup_ff <= gpio_port_pkg::RST_PIN_OUT;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      pin_pullup_ff <= nxt_pin_pullup;
    end
  end

  assign pin_o = pin_out_ff;
  assign pin_oe_o = pin_oe_ff;
  assign pin_pullup_o = pin_pullup_ff;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // pin levels, analog reads 0
  wire [7:0] port0_pins = pin_sync_ff[7:0] & port0_input_mode_ff;
  wire [7:0] port1_pins = pin_sync_ff[15:8] & port1_input_mode_ff;
  wire port2_pin = pin_sync_ff[gpio_port_pkg::P2_PIN];

  logic [7:0] nxt_rdata; // Selected read value

  // Latches come back for read-modify-write, pins otherwise
  // Reading pins for a read-modify-write would copy the level of an
  // open-drain pin held low from outside back into its latch, so the
  // latch is returned instead. Plain reads always see the pins, even
  // when a peripheral owns the pin.
  always_comb begin
    nxt_rdata = 8'h00;
    if (sel_p0) begin
      nxt_rdata = sfr_rmw_i ? port0_latch_ff : port0_pins;
    end else if (sel_p1) begin
      nxt_rdata = sfr_rmw_i ? port1_latch_ff : port1_pins;
    end else if (sel_p2) begin
      nxt_rdata = {7'h00, sfr_rmw_i ? port2_latch_ff : port2_pin};
    end else if (sel_p0_mdin) begin
      nxt_rdata = port0_input_mode_ff;
    end else if (sel_p1_mdin) begin
      nxt_rdata = port1_input_mode_ff;
    end else if (sel_p0_mdout) begin
      nxt_rdata = port0_output_mode_ff;
    end else if (sel_p1_mdout) begin
      nxt_rdata = port1_output_mode_ff;
    end else if (sel_p2_mdout) begin
      nxt_rdata = {7'h00, port2_output_mode_ff};
    end else if (sel_p0_skip) begin
      nxt_rdata = port0_crossbar_skip_ff;
    end else if (sel_p1_skip) begin
      nxt_rdata = {1'b0, port1_crossbar_skip_ff};
    end else begin
      // Unmapped addresses read zero
      nxt_rdata = 8'h00;
    end
  end

  // Read data held until the next read
  // The bit test uses the same selected byte, so a bit read of a
  // port obeys the same pin or latch choice as a byte read.
  // Both results stand until the next read strobe.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_ff <= gpio_port_pkg::RST_RDATA;
      rbit_ff <= 1'b0;
    end else if (sfr_rd_i) begin
      rdata_ff <= nxt_rdata;
      rbit_ff <= nxt_rdata[sfr_bit_idx_i];
    end
  end

  assign sfr_rdata_o = rdata_ff;
  assign sfr_rbit_o = rbit_ff;

endmodule : general_purpose_port_io

/* File: testbench/gpio_port_props.sv */
// Checker of the port block's pin and register port timing.
// Assumes it is bound into the top module; one clock domain.
`timescale 1ns/1ps
module gpio_port_props (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_bit_wr_i,
  input wire logic [2:0] sfr_bit_idx_i,
  input wire logic sfr_rd_i,
  input wire logic sfr_rmw_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic sfr_rbit_o,
  input wire logic crossbar_global_enable_i,
  input wire logic weak_pullup_disable_i,
  input wire logic [16:0] xbar_claim_i,
  input wire logic [16:0] two_wire_pin_i,
  input wire logic [16:0] pin_digital_o,
  input wire logic [16:0] pin_i,
  input wire logic [16:0] pin_o,
  input wire logic [16:0] pin_oe_o,
  input wire logic [16:0] pin_pullup_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  xbar_off_a: assert property (
    !crossbar_global_enable_i |=> pin_oe_o == 17'h00000) else $error("driver on, crossbar off");
  analog_off_a: assert property (
    ((pin_oe_o | pin_pullup_o) & ~($past(pin_digital_o) | $past(pin_digital_o, 2))) == 17'h00000)
    else $error("analog pin driven or pulled");
  two_wire_od_a: assert property ((pin_o & $past(two_wire_pin_i)) == 17'h00000)
    else $error("two-wire pin driven high");
  pullup_excl_a: assert property ((pin_oe_o & pin_pullup_o) == 17'h00000)
    else $error("pullup on a driven pin");
  pullup_off_a: assert property (weak_pullup_disable_i |=> pin_pullup_o == 17'h00000)
    else $error("pullup while disabled");
  drive_low_a: assert property (
    (sfr_wr_i && sfr_addr_i == gpio_port_pkg::ADDR_PORT0_LATCH) ##1 (!sfr_wr_i && !sfr_bit_wr_i)
    ##1 (crossbar_global_enable_i && xbar_claim_i[7:0] == 8'h00)
    |=> ((~pin_oe_o[7:0] | pin_o[7:0]) & ~$past(sfr_wdata_i, 3) & pin_digital_o[7:0]
    & $past(pin_digital_o[7:0]) & $past(pin_digital_o[7:0], 2)) == 8'h00)
    else $error("latch zero not driven low");
  read_pins_a: assert property (
    (sfr_rd_i && !sfr_rmw_i && sfr_addr_i == gpio_port_pkg::ADDR_PORT0_LATCH
    && $stable(pin_i[7:0]) && $past(pin_i[7:0]) == $past(pin_i[7:0], 2)
    && $past(pin_i[7:0], 2) == $past(pin_i[7:0], 3) && $stable(pin_digital_o[7:0]))
    |=> sfr_rdata_o == $past(pin_i[7:0] & pin_digital_o[7:0])) else $error("pin read wrong");
  rmw_latch_a: assert property (
    (sfr_wr_i && sfr_addr_i == gpio_port_pkg::ADDR_PORT1_LATCH) ##1 (!sfr_wr_i && !sfr_bit_wr_i)
    ##1 (sfr_rd_i && sfr_rmw_i && sfr_addr_i == gpio_port_pkg::ADDR_PORT1_LATCH)
    |=> sfr_rdata_o == $past(sfr_wdata_i, 3)) else $error("rmw read not latch");
  skip_msb_a: assert property (
    sfr_rd_i && sfr_addr_i == gpio_port_pkg::ADDR_PORT1_CROSSBAR_SKIP |=> !sfr_rdata_o[7])
    else $error("unused skip bit set");
  port2_bits_a: assert property (sfr_rd_i && (sfr_addr_i == gpio_port_pkg::ADDR_PORT2_LATCH
    || sfr_addr_i == gpio_port_pkg::ADDR_PORT2_OUTPUT_MODE) |=> sfr_rdata_o[7:1] == 7'h00)
    else $error("unused port2 bits set");
  read_bit_a: assert property (
    sfr_rd_i |=> sfr_rbit_o == sfr_rdata_o[$past(sfr_bit_idx_i)]) else $error("bit test wrong");
endmodule : gpio_port_props
bind general_purpose_port_io gpio_port_props gpio_port_props_inst (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_bit_wr_i(sfr_bit_wr_i), .sfr_bit_idx_i(sfr_bit_idx_i),
  .sfr_rd_i(sfr_rd_i), .sfr_rmw_i(sfr_rmw_i), .sfr_rdata_o(sfr_rdata_o), .sfr_rbit_o(sfr_rbit_o),
  .crossbar_global_enable_i(crossbar_global_enable_i), .pin_i(pin_i), .pin_o(pin_o),
  .weak_pullup_disable_i(weak_pullup_disable_i), .xbar_claim_i(xbar_claim_i),
  .two_wire_pin_i(two_wire_pin_i), .pin_digital_o(pin_digital_o), .pin_oe_o(pin_oe_o),
  .pin_pullup_o(pin_pullup_o));

/* File: testbench/pin_partner.sv */
// Outside circuitry on the seventeen pins.
// Assumes the device enables its driver only while it drives.
`timescale 1ns/1ps
module pin_partner (
  input wire logic core_clk_i,
  input wire logic [16:0] pin_o_i,
  input wire logic [16:0] pin_oe_i,
  input wire logic [16:0] pin_pullup_i,
  input wire logic [16:0] ext_val_i,
  input wire logic [16:0] ext_en_i,
  output logic [16:0] pin_level_o
);
  // Floating lines wander each cycle so a stale level never passes
  logic [16:0] drift_ff = 17'h0AAAA;
  always_ff @(posedge core_clk_i) begin
    drift_ff <= ~drift_ff;
  end
  // Outside driver, else weak pullup, else floating
  wire logic [16:0] idle_lvl = (ext_en_i & ext_val_i) | (~ext_en_i & (pin_pullup_i | drift_ff));
  // Device driver wins where enabled
  assign pin_level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & idle_lvl);
endmodule : pin_partner

/* File: testbench/testbench.sv */
// Self-checking bench of the general purpose port block.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
module testbench;
  logic core_clk_i, reset_i, wr, bwr, bval, rd, rmw, en, wpd;
  logic [7:0] addr, wdata;
  logic [2:0] idx;
  logic [16:0] claim, xdata, tw, ext_val, ext_en, lat, om, im, lvl, pp, e_oe;
  logic [14:0] sk;
  logic [31:0] seed, r;
  int error_cnt, checks_done;
  wire logic [16:0] pin_lvl, pin_o, pin_oe, pin_pu, dig;
  wire logic [14:0] skip;
  wire logic [7:0] rdata;
  wire logic rbit;
  // Register table: address, reset value, implemented bits
  logic [7:0] ta [11] = '{8'h80, 8'h90, 8'hA0, 8'hA4, 8'hA5, 8'hA6, 8'hD4, 8'hD5, 8'hF1, 8'hF2, 8'h81};
  logic [7:0] tr [11] = '{8'hFF, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
  logic [7:0] tm [11] = '{8'hFF, 8'hFF, 8'h01, 8'hFF, 8'hFF, 8'h01, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h00};
  general_purpose_port_io general_purpose_port_io_inst (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_wdata_i(wdata), .sfr_bit_wr_i(bwr), .sfr_bit_idx_i(idx), .sfr_bit_wdata_i(bval),
    .sfr_rd_i(rd), .sfr_rmw_i(rmw), .sfr_rdata_o(rdata), .sfr_rbit_o(rbit),
    .crossbar_global_enable_i(en), .weak_pullup_disable_i(wpd), .xbar_claim_i(claim),
    .xbar_data_i(xdata), .two_wire_pin_i(tw), .crossbar_skip_o(skip), .pin_digital_o(dig),
    .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_o(pin_oe), .pin_pullup_o(pin_pu));
  pin_partner pin_partner_inst (.core_clk_i(core_clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
    .pin_pullup_i(pin_pu), .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_level_o(pin_lvl));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic do_reset();
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    lat = '1;
    om = '0;
    im = '1;
    sk = '0;
  endtask : do_reset
  // Byte write; the shadow keeps only implemented bits
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
    case (a)
      8'h80: lat[7:0] = d;
      8'h90: lat[15:8] = d;
      8'hA0: lat[16] = d[0];
      8'hA4: om[7:0] = d;
      8'hA5: om[15:8] = d;
      8'hA6: om[16] = d[0];
      8'hD4: sk[7:0] = d;
      8'hD5: sk[14:8] = d[6:0];
      8'hF1: im[7:0] = d;
      8'hF2: im[15:8] = d;
      default: ;
    endcase
  endtask : wreg
  task automatic breg(input logic [7:0] a, input logic [2:0] i, input logic v);
    @(posedge core_clk_i);
    addr <= a;
    idx <= i;
    bval <= v;
    bwr <= 1'b1;
    @(posedge core_clk_i);
    bwr <= 1'b0;
    if (a == 8'h80) lat[i] = v;
    if (a == 8'h90) lat[8 + i] = v;
    if (a == 8'hA0 && i == 3'h0) lat[16] = v;
  endtask : breg
  // Read, random bit index; data checked once the read edge has landed
  task automatic rreg(input logic [7:0] a, input logic m, input logic [7:0] exp);
    logic [31:0] q;
    q = rnd();
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    rmw <= m;
    idx <= q[2:0];
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1;
    chk("read data", rdata, exp);
    chk("read bit", rbit, exp[idx]);
  endtask : rreg
  // Pin drive model: claimed pins take peripheral data
  task automatic pins();
    lvl = (claim & xdata) | (~claim & lat);
    pp = om & im & ~tw;
    e_oe = {17{en}} & im & (pp | ~lvl);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("pin enable", pin_oe, e_oe);
    chk("pin out", pin_o, lvl & pp);
    chk("pin pullup", pin_pu, {17{~wpd}} & im & ~pp & ~e_oe);
  endtask : pins
  task automatic defaults();
    for (int i = 0; i < 11; i++) rreg(ta[i], 1'b1, tr[i]);
    chk("skip", skip, 15'h0000);
  endtask : defaults
  initial begin
    {reset_i, wr, bwr, bval, rd, rmw, en, wpd, addr, wdata, idx} = '0;
    reset_i = 1'b1;
    {claim, xdata, tw, ext_val} = '0;
    ext_en = '1;
    seed = 32'h3FAF8EA2;
    do_reset();
    defaults();
    $display("test reset values done");
    for (int i = 0; i < 11; i++) begin
      r = rnd();
      wreg(ta[i], r[7:0]);
      rreg(ta[i], 1'b1, r[7:0] & tm[i]);
    end
    chk("skip", skip, sk);
    chk("digital", dig, im);
    $display("test registers done");
    @(posedge core_clk_i);
    r = rnd();
    ext_val <= r[16:0];
    pins();
    rreg(8'h80, 1'b0, ext_val[7:0] & im[7:0]);
    rreg(8'h90, 1'b0, ext_val[15:8] & im[15:8]);
    rreg(8'hA0, 1'b0, {7'h00, ext_val[16]});
    $display("test pin reads done");
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk_i);
      r = rnd();
      en <= 1'b1;
      ext_en <= '0;
      claim <= r[16:0] & 17'h1FF00;
      wpd <= r[20];
      xdata <= r[31:15];
      r = rnd();
      tw <= r[16:0];
      for (int j = 0; j < 10; j++) wreg(ta[j], 8'(rnd()));
      wreg(8'hD4, ~im[7:0] | sk[7:0]);
      wreg(8'hD5, ~im[15:8] | {1'b0, sk[14:8]});
      pins();
      breg(8'h80, i[2:0], r[30]);
      rreg(8'h80, 1'b1, lat[7:0]);
      wreg(8'h90, r[28:21]);
      rreg(8'h90, 1'b1, lat[15:8]);
    end
    breg(8'hA0, 3'h3, ~lat[16]);
    rreg(8'hA0, 1'b1, {7'h00, lat[16]});
    $display("test drive done");
    do_reset();
    defaults();
    $display("test second reset done");
    results();
  end
  initial begin
    #200000;
    error_cnt++;
    $display("watchdog expired");
    results();
  end
endmodule : testbench
